// ---- src/fp_round_pkg.sv ----
package fp_round_pkg;

  // ------------------------------------------------------------------
  // Register map and field layout
  // ------------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] CTX_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  localparam int unsigned FLAG_W = 6;
  localparam int unsigned CTX_MODE_LSB = 0;
  localparam int unsigned CTX_ENABLE_LSB = 2;
  localparam int unsigned CTX_FLAGS_LSB = 8;
  localparam int unsigned STATUS_CLS_A_LSB = 8;
  localparam int unsigned STATUS_CLS_B_LSB = 11;
  localparam logic [FLAG_W-1:0] FLAGS_RESET = 6'h00;
  localparam logic [FLAG_W-1:0] ENABLE_RESET = 6'h00;

  // Bit positions of the accumulated exception flags.
  localparam int unsigned FLAG_ILLEGAL = 0;
  localparam int unsigned FLAG_INEXACT = 1;
  localparam int unsigned FLAG_OVERFLOW = 2;
  localparam int unsigned FLAG_UNDERFLOW = 3;
  localparam int unsigned FLAG_DIVZERO = 4;
  localparam int unsigned FLAG_INVALID = 5;

  // ------------------------------------------------------------------
  // Format constants
  // ------------------------------------------------------------------
  localparam logic signed [12:0] SGL_BIAS = 13'h007f;
  localparam logic signed [12:0] DBL_BIAS = 13'h03ff;
  localparam logic signed [12:0] SGL_EXP_MAX = 13'h00ff;
  localparam logic signed [12:0] DBL_EXP_MAX = 13'h07ff;
  localparam logic signed [12:0] EXP_MIN_NORMAL = 13'h0001;
  localparam logic signed [12:0] FIX_SHIFT_MAX = 13'h001f;
  localparam logic [33:0] INT_MAG_MAX_POS = 34'h07fffffff;
  localparam logic [33:0] INT_MAG_MAX_NEG = 34'h080000000;
  localparam logic [31:0] INT_SAT_POS = 32'h7fffffff;
  localparam logic [31:0] INT_SAT_NEG = 32'h80000000;

  typedef enum logic [1:0] {
    round_nearest_even, round_toward_zero, round_up_positive, round_down_negative
  } round_mode_t;

  typedef enum logic [2:0] {
    op_add, op_sub, op_mul, op_div, op_fix, op_move
  } op_kind_t;

  typedef enum logic [2:0] {
    class_zero, subnormal_number, normal_number, unbounded_value_class, not_a_number
  } class_t;

  // Sorts an operand into its encoding class; single values sit in the low word.
  function automatic class_t classify(input logic [63:0] x, input logic dbl);
    logic exp_ones;
    logic exp_zero;
    logic frac_zero;
    exp_ones = dbl ? (&x[62:52]) : (&x[30:23]);
    exp_zero = dbl ? ~(|x[62:52]) : ~(|x[30:23]);
    frac_zero = dbl ? ~(|x[51:0]) : ~(|x[22:0]);
    if (exp_ones) begin
      classify = frac_zero ? unbounded_value_class : not_a_number;
    end else if (exp_zero) begin
      classify = frac_zero ? class_zero : subnormal_number;
    end else begin
      classify = normal_number;
    end
  endfunction : classify

  // Decides whether the kept magnitude is incremented by one unit in the last place.
  function automatic logic round_up(input round_mode_t mode, input logic sign,
                                    input logic lsb, input logic g, input logic s);
    unique case (mode)
      round_nearest_even: round_up = g & (s | lsb);
      round_toward_zero: round_up = 1'b0;
      round_up_positive: round_up = ~sign & (g | s);
      round_down_negative: round_up = sign & (g | s);
    endcase
  endfunction : round_up

  // Packs sign, exponent and fraction into the precision's layout.
  function automatic logic [63:0] pack(input logic dbl, input logic sign,
                                       input logic [10:0] e, input logic [51:0] f);
    pack = dbl ? {sign, e, f} : {32'h00000000, sign, e[7:0], f[22:0]};
  endfunction : pack

endpackage : fp_round_pkg

// ---- src/fp_round_and_exception_unit.sv ----
// The register offsets and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
module fp_round_and_exception_unit (
  input wire mclk,
  input wire rst,
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_write,
  input wire reg_read,
  output logic [31:0] reg_rdata,
  input wire cmd_valid,
  input wire cmd_read,
  input wire cmd_known,
  input wire cmd_store,
  input wire op_valid,
  input fp_round_pkg::op_kind_t op_kind,
  input wire op_double,
  input wire [63:0] operand_a,
  input wire [63:0] operand_b,
  input wire res_sign,
  input wire signed [12:0] res_exp,
  input wire [55:0] res_mant,
  output logic result_valid,
  output logic [63:0] result,
  output logic [5:0] result_flags,
  output logic irq
);

  // ------------------------------------------------------------------
  // Context state
  // ------------------------------------------------------------------
  fp_round_pkg::round_mode_t round_mode;
  logic [5:0] enable;
  logic [5:0] flags;
  fp_round_pkg::class_t last_cls_a;
  fp_round_pkg::class_t last_cls_b;
  logic ctx_write;
  logic illegal_now;

  assign ctx_write = reg_write && (reg_addr == fp_round_pkg::CTX_OFFSET);
  // Illegal opcodes and non-store reads are caught as they arrive.
  assign illegal_now = cmd_valid && (!cmd_known || (cmd_read && !cmd_store));

  // ------------------------------------------------------------------
  // Operand classification
  // ------------------------------------------------------------------
  fp_round_pkg::class_t cls_a;
  fp_round_pkg::class_t cls_b;
  logic a_zero, b_zero, a_inf, b_inf, a_nan, b_nan, any_nan, sign_a, sign_b, eff_b;

  // Subnormals count as zero here, so the special cases see them flushed.
  always_comb begin
    cls_a = fp_round_pkg::classify(operand_a, op_double);
    cls_b = fp_round_pkg::classify(operand_b, op_double);
    a_zero = (cls_a == fp_round_pkg::class_zero) || (cls_a == fp_round_pkg::subnormal_number);
    b_zero = (cls_b == fp_round_pkg::class_zero) || (cls_b == fp_round_pkg::subnormal_number);
    a_inf = cls_a == fp_round_pkg::unbounded_value_class;
    b_inf = cls_b == fp_round_pkg::unbounded_value_class;
    a_nan = cls_a == fp_round_pkg::not_a_number;
    b_nan = cls_b == fp_round_pkg::not_a_number;
    any_nan = a_nan || ((op_kind != fp_round_pkg::op_fix) &&
                        (op_kind != fp_round_pkg::op_move) && b_nan);
    sign_a = op_double ? operand_a[63] : operand_a[31];
    sign_b = op_double ? operand_b[63] : operand_b[31];
    eff_b = sign_b ^ (op_kind == fp_round_pkg::op_sub);
  end

  // ------------------------------------------------------------------
  // Rounding path for floating results
  // ------------------------------------------------------------------
  logic [52:0] keep;
  logic [53:0] sum;
  logic guard, sticky, inc, carry, res_ovf, res_unf, res_inexact, unnorm;
  logic signed [12:0] exp_r;
  logic signed [12:0] exp_max;
  logic [51:0] frac_r;

  always_comb begin
    exp_max = op_double ? fp_round_pkg::DBL_EXP_MAX : fp_round_pkg::SGL_EXP_MAX;
    if (op_double) begin
      keep = res_mant[55:3];
      guard = res_mant[2];
      sticky = |res_mant[1:0];
    end else begin
      keep = {29'h00000000, res_mant[55:32]};
      guard = res_mant[31];
      sticky = |res_mant[30:0];
    end
    inc = fp_round_pkg::round_up(round_mode, res_sign, keep[0], guard, sticky);
    sum = {1'b0, keep} + {53'h0, inc};
    carry = op_double ? sum[53] : sum[24];
    exp_r = res_exp + {12'h000, carry};
    frac_r = op_double ? sum[51:0] : {29'h00000000, sum[22:0]};
    unnorm = !res_mant[55];
    res_inexact = !unnorm && (guard || sticky);
    res_ovf = !unnorm && (exp_r >= exp_max);
    res_unf = (res_mant != 56'h0) && (unnorm || (exp_r < fp_round_pkg::EXP_MIN_NORMAL));
  end

  // ------------------------------------------------------------------
  // Float-to-integer path
  // ------------------------------------------------------------------
  logic signed [12:0] unb_exp;
  logic [55:0] frac_rest;
  logic [33:0] int_part, int_r;
  logic [5:0] shift;
  logic fix_g, fix_s, fix_inc, fix_big, fix_ovf;
  logic [31:0] int_val;

  always_comb begin
    unb_exp = res_exp - (op_double ? fp_round_pkg::DBL_BIAS : fp_round_pkg::SGL_BIAS);
    shift = 6'h00;
    frac_rest = 56'h0;
    int_part = 34'h0;
    fix_big = 1'b0;
    fix_g = 1'b0;
    fix_s = 1'b0;
    if (!res_mant[55]) begin
      fix_s = 1'b0;
    end else if (unb_exp < 13'sh0000) begin
      fix_g = (unb_exp == -13'sh0001);
      fix_s = (unb_exp == -13'sh0001) ? (|res_mant[54:0]) : 1'b1;
    end else if (unb_exp > fp_round_pkg::FIX_SHIFT_MAX) begin
      fix_big = 1'b1;
    end else begin
      shift = unb_exp[5:0];
      int_part = 34'(res_mant >> (6'd55 - shift));
      frac_rest = res_mant << (shift + 6'd1);
      fix_g = frac_rest[55];
      fix_s = |frac_rest[54:0];
    end
    fix_inc = fp_round_pkg::round_up(round_mode, res_sign, int_part[0], fix_g, fix_s);
    int_r = int_part + {33'h0, fix_inc};
    // The integer range is one wider on the negative side.
    fix_ovf = fix_big || (res_sign ? (int_r > fp_round_pkg::INT_MAG_MAX_NEG)
                                   : (int_r > fp_round_pkg::INT_MAG_MAX_POS));
    int_val = res_sign ? (32'h0 - int_r[31:0]) : int_r[31:0];
  end

  // ------------------------------------------------------------------
  // Special-case selection
  // ------------------------------------------------------------------
  logic [63:0] next_result, qnan, inf_a, inf_b;
  logic [5:0] next_flags;
  logic mul_sign;

  always_comb begin
    mul_sign = sign_a ^ sign_b;
    qnan = fp_round_pkg::pack(op_double, 1'b0, 11'h7ff, 52'hfffffffffffff);
    inf_a = fp_round_pkg::pack(op_double, sign_a, 11'h7ff, 52'h0);
    inf_b = fp_round_pkg::pack(op_double, eff_b, 11'h7ff, 52'h0);
    next_flags = 6'h00;
    next_result = 64'h0;
    if (any_nan) begin
      next_flags[fp_round_pkg::FLAG_INVALID] = 1'b1;
      next_result = qnan;
    end else if (op_kind == fp_round_pkg::op_fix) begin
      if (a_inf || fix_ovf) begin
        next_flags[fp_round_pkg::FLAG_OVERFLOW] = 1'b1;
        next_result = {32'h0, sign_a ? fp_round_pkg::INT_SAT_NEG : fp_round_pkg::INT_SAT_POS};
      end else if (a_zero) begin
        next_result = 64'h0;
      end else begin
        next_flags[fp_round_pkg::FLAG_INEXACT] = fix_g || fix_s;
        next_result = {32'h0, int_val};
      end
    end else if ((op_kind == fp_round_pkg::op_mul) && ((a_inf && b_zero) || (a_zero && b_inf))) begin
      next_flags[fp_round_pkg::FLAG_INVALID] = 1'b1;
      next_result = qnan;
    end else if ((op_kind == fp_round_pkg::op_div) && ((a_zero && b_zero) || (a_inf && b_inf))) begin
      next_flags[fp_round_pkg::FLAG_INVALID] = 1'b1;
      next_result = qnan;
    end else if (((op_kind == fp_round_pkg::op_add) || (op_kind == fp_round_pkg::op_sub)) &&
                 a_inf && b_inf && (sign_a != eff_b)) begin
      next_flags[fp_round_pkg::FLAG_INVALID] = 1'b1;
      next_result = qnan;
    end else if ((op_kind == fp_round_pkg::op_div) && !a_inf && b_zero) begin
      next_flags[fp_round_pkg::FLAG_DIVZERO] = 1'b1;
      next_result = fp_round_pkg::pack(op_double, mul_sign, 11'h7ff, 52'h0);
    end else if ((op_kind == fp_round_pkg::op_mul) || (op_kind == fp_round_pkg::op_div)) begin
      if (a_inf || ((op_kind == fp_round_pkg::op_mul) && b_inf)) begin
        next_result = fp_round_pkg::pack(op_double, mul_sign, 11'h7ff, 52'h0);
      end else if (a_zero || b_zero || b_inf) begin
        next_result = fp_round_pkg::pack(op_double, mul_sign, 11'h000, 52'h0);
      end else begin
        next_result = 64'h0;
        next_flags = 6'h3f;
      end
    end else if ((op_kind != fp_round_pkg::op_move) && (a_inf || b_inf)) begin
      next_result = a_inf ? inf_a : inf_b;
    end else if ((op_kind != fp_round_pkg::op_move) && b_zero) begin
      next_result = a_zero ?
        fp_round_pkg::pack(op_double, (round_mode == fp_round_pkg::round_down_negative) ?
                           (sign_a | eff_b) : (sign_a & eff_b), 11'h000, 52'h0) :
        fp_round_pkg::pack(op_double, sign_a, op_double ? operand_a[62:52] :
                           {3'h0, operand_a[30:23]}, op_double ? operand_a[51:0] :
                           {29'h0, operand_a[22:0]});
    end else if ((op_kind != fp_round_pkg::op_move) && a_zero) begin
      next_result = fp_round_pkg::pack(op_double, eff_b, op_double ? operand_b[62:52] :
                           {3'h0, operand_b[30:23]}, op_double ? operand_b[51:0] :
                           {29'h0, operand_b[22:0]});
    end else begin
      next_result = 64'h0;
      next_flags = 6'h3f;
    end
    // A flag pattern of all ones marks the ordinary rounded path.
    if (next_flags == 6'h3f) begin
      next_flags = 6'h00;
      next_flags[fp_round_pkg::FLAG_INEXACT] = res_inexact;
      if (res_ovf) begin
        next_flags[fp_round_pkg::FLAG_OVERFLOW] = 1'b1;
        next_flags[fp_round_pkg::FLAG_INEXACT] = 1'b1;
        if ((round_mode == fp_round_pkg::round_nearest_even) ||
            ((round_mode == fp_round_pkg::round_up_positive) && !res_sign) ||
            ((round_mode == fp_round_pkg::round_down_negative) && res_sign)) begin
          next_result = fp_round_pkg::pack(op_double, res_sign, 11'h7ff, 52'h0);
        end else begin
          next_result = fp_round_pkg::pack(op_double, res_sign,
                          op_double ? 11'h7fe : 11'h0fe, 52'hfffffffffffff);
        end
      end else if (res_unf) begin
        next_flags[fp_round_pkg::FLAG_UNDERFLOW] = 1'b1;
        next_result = fp_round_pkg::pack(op_double, res_sign, 11'h000, 52'h0);
      end else if (unnorm) begin
        next_result = fp_round_pkg::pack(op_double, res_sign, 11'h000, 52'h0);
      end else begin
        next_result = fp_round_pkg::pack(op_double, res_sign, exp_r[10:0], frac_r);
      end
    end
  end

  // ------------------------------------------------------------------
  // Result register
  // ------------------------------------------------------------------
  // Each accepted operation delivers its result and flags one cycle later.
  always_ff @(posedge mclk) begin
    if (rst) begin
      result_valid <= 1'b0;
      result <= 64'h0;
      result_flags <= 6'h00;
    end else begin
      result_valid <= op_valid;
      if (op_valid) begin
        result <= next_result;
        result_flags <= next_flags;
      end else begin
        result_flags <= 6'h00;
      end
    end
  end

  // Classes of the last operands are kept for software to inspect.
  always_ff @(posedge mclk) begin
    if (rst) begin
      last_cls_a <= fp_round_pkg::class_zero;
      last_cls_b <= fp_round_pkg::class_zero;
    end else if (op_valid) begin
      last_cls_a <= cls_a;
      last_cls_b <= cls_b;
    end
  end

  // ------------------------------------------------------------------
  // Context word and interrupt
  // ------------------------------------------------------------------
  // Mode and enables load on a context write.
  always_ff @(posedge mclk) begin
    if (rst) begin
      round_mode <= fp_round_pkg::round_nearest_even;
      enable <= fp_round_pkg::ENABLE_RESET;
    end else if (ctx_write) begin
      round_mode <= fp_round_pkg::round_mode_t'(reg_wdata[fp_round_pkg::CTX_MODE_LSB +: 2]);
      enable <= reg_wdata[fp_round_pkg::CTX_ENABLE_LSB +: fp_round_pkg::FLAG_W];
    end
  end

  // Flags hold until a context write; a new event beats a clear in the same cycle.
  always_ff @(posedge mclk) begin
    if (rst) begin
      flags <= fp_round_pkg::FLAGS_RESET;
    end else begin
      flags <= (ctx_write ? reg_wdata[fp_round_pkg::CTX_FLAGS_LSB +: fp_round_pkg::FLAG_W]
                          : flags) |
               (op_valid ? next_flags : 6'h00) |
               {5'h00, illegal_now};
    end
  end

  // The interrupt follows any accumulated flag whose enable is set.
  assign irq = |(flags & enable);

  // Register reads answer in the following cycle; unmapped offsets read zero.
  always_ff @(posedge mclk) begin
    if (rst) begin
      reg_rdata <= 32'h0;
    end else if (reg_read && (reg_addr == fp_round_pkg::CTX_OFFSET)) begin
      reg_rdata <= {18'h0, flags, enable, round_mode};
    end else if (reg_read && (reg_addr == fp_round_pkg::STATUS_OFFSET)) begin
      reg_rdata <= {18'h0, last_cls_b, last_cls_a, 2'h0, result_flags};
    end else begin
      reg_rdata <= 32'h0;
    end
  end

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  chk_nan_invalid: assert property (
    op_valid && a_nan |=> result_flags[fp_round_pkg::FLAG_INVALID] && flags[5])
    else $error("NaN input did not raise invalid");
  chk_default_nan: assert property (
    op_valid && op_double && (op_kind == fp_round_pkg::op_mul) && a_inf && b_zero
    |=> result == 64'h7fffffffffffffff)
    else $error("invalid result is not the default NaN");
  chk_divzero_inf: assert property (
    op_valid && !op_double && (op_kind == fp_round_pkg::op_div) &&
    (cls_a == fp_round_pkg::normal_number) && b_zero
    |=> result[30:0] == 31'h7f800000 && result_flags[fp_round_pkg::FLAG_DIVZERO])
    else $error("divide by zero result wrong");
  chk_illegal_read: assert property (
    cmd_valid && cmd_read && !cmd_store |=> flags[fp_round_pkg::FLAG_ILLEGAL])
    else $error("non-store read did not flag illegal opcode");
  chk_flags_sticky: assert property (
    !ctx_write ##1 !ctx_write |-> (flags & $past(flags)) == $past(flags))
    else $error("accumulated flag dropped without a context write");
  chk_irq_enable: assert property (
    result_valid && |(result_flags & enable) |-> irq)
    else $error("enabled exception did not interrupt");
  chk_underflow_zero: assert property (
    result_valid && result_flags[fp_round_pkg::FLAG_UNDERFLOW] && !$past(op_double)
    |-> result[30:0] == 31'h0)
    else $error("underflow result not flushed");
  chk_ovf_largest: assert property (
    op_valid && op_double && (op_kind == fp_round_pkg::op_move) && !a_nan &&
    (round_mode == fp_round_pkg::round_toward_zero) && res_mant[55] && (res_exp > 13'sh07ff)
    |=> result[62:0] == 63'h7fefffffffffffff)
    else $error("toward-zero overflow not largest finite");
  chk_single_normal: assert property (
    op_valid && !op_double && (op_kind == fp_round_pkg::op_move) && res_mant[55] && !a_nan &&
    (round_mode == fp_round_pkg::round_toward_zero) && (res_exp > 13'sh0000) &&
    (res_exp < 13'sh00ff) |=> result[30:23] == $past(res_exp[7:0]))
    else $error("single normal exponent not kept");

  cov_overflow: cover property (result_valid && result_flags[fp_round_pkg::FLAG_OVERFLOW]);
  cov_divzero: cover property (result_valid && result_flags[fp_round_pkg::FLAG_DIVZERO]);
  cov_tie_even: cover property (op_valid && guard && !sticky && !keep[0]);
  cov_irq: cover property (irq);

endmodule : fp_round_and_exception_unit

// ---- test/fp_host_model.sv ----
`timescale 1ns/1ps
// Host model: plain register port, one-cycle strobes, read data one cycle later.
module fp_host_model (
  input wire mclk,
  input wire [31:0] reg_rdata,
  output logic [7:0] reg_addr,
  output logic [31:0] reg_wdata,
  output logic reg_write,
  output logic reg_read
);
  // The bus is idle from time zero.
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 32'h00000000;
    reg_write = 1'b0;
    reg_read = 1'b0;
  end

  // Write strobe for one cycle beside address and data.
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_write <= 1'b1;
    @(posedge mclk);
    reg_write <= 1'b0;
  endtask : wr

  // Read strobe for one cycle; data are taken in the following cycle only.
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge mclk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge mclk);
    reg_read <= 1'b0;
    #1;
    v = reg_rdata;
  endtask : rd
endmodule : fp_host_model

// ---- test/fp_round_and_exception_unit_bench.sv ----
`timescale 1ns/1ps
// Bench: the host model reaches the registers, the bench issues operations.
module fp_round_and_exception_unit_bench;
  logic mclk = 1'b0, rst = 1'b1, cmd_valid = 1'b0, cmd_read = 1'b0, cmd_known = 1'b0;
  logic cmd_store = 1'b0, op_valid = 1'b0, op_double = 1'b0, res_sign = 1'b0;
  logic result_valid, irq, reg_write, reg_read, s, g, st, up;
  logic [63:0] operand_a = 64'h0, operand_b = 64'h0, result, want;
  logic signed [12:0] res_exp = 13'h0000;
  logic [55:0] res_mant = 56'h0;
  logic [31:0] reg_rdata, reg_wdata, d, lo;
  logic [7:0] reg_addr;
  logic [5:0] result_flags;
  logic [22:0] fr;
  fp_round_pkg::op_kind_t op_kind = fp_round_pkg::op_move;
  int err_total = 0, checks = 0, cyc = 0, md;
  localparam logic [55:0] unit_mant = 56'h80000000000000;
  fp_host_model i_host (.mclk, .reg_rdata, .reg_addr, .reg_wdata, .reg_write, .reg_read);
  fp_round_and_exception_unit i_dut (.mclk, .rst, .reg_addr, .reg_wdata, .reg_write,
    .reg_read, .reg_rdata, .cmd_valid, .cmd_read, .cmd_known, .cmd_store, .op_valid,
    .op_kind, .op_double, .operand_a, .operand_b, .res_sign, .res_exp, .res_mant,
    .result_valid, .result, .result_flags, .irq);

  // Clock, and a watchdog that ends a hung run as a failure.
  always #10 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      wrap_up();
    end
  end

  // Prints the verdict and ends the run.
  task automatic wrap_up();
    if (err_total == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : wrap_up

  // Compares a seen value with the expected one.
  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp_v);
    checks++;
    if (seen !== exp_v) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, exp_v, seen);
    end
  endtask : chk

  // Issues one operation; the result stands one cycle after it is taken.
  task automatic op(input fp_round_pkg::op_kind_t k, input logic [63:0] a, b,
                    input logic sg, input logic signed [12:0] e, input logic [55:0] m);
    @(posedge mclk);
    op_kind <= k;
    {op_valid, operand_a, operand_b, res_sign, res_exp, res_mant} <= {1'b1, a, b, sg, e, m};
    @(posedge mclk);
    op_valid <= 1'b0;
    #1;
  endtask : op

  // Issues one operation and compares its result word and flags.
  task automatic run(input fp_round_pkg::op_kind_t k, input logic [63:0] a, b,
                     input logic [63:0] r, input logic [5:0] f);
    op(k, a, b, 1'b0, 13'h007f, unit_mant);
    chk("valid", 64'(result_valid), 64'h1);
    chk("result", result, r);
    chk("flags", 64'(result_flags), 64'(f));
  endtask : run

  // Passes an operand through and reads back its encoding class.
  task automatic cls(input logic dbl, input logic [63:0] a, input logic [2:0] c);
    @(posedge mclk) op_double <= dbl;
    op(fp_round_pkg::op_move, a, 64'h0, 1'b0, 13'h007f, unit_mant);
    i_host.rd(8'h04, d);
    chk("class", 64'(d[10:8]), 64'(c));
  endtask : cls

  // Clears the flags, issues one bus command and reads the illegal-opcode flag.
  task automatic cmd(input logic r, k, w, e);
    i_host.wr(8'h00, 32'h00000000);
    @(posedge mclk);
    {cmd_valid, cmd_read, cmd_known, cmd_store} <= {1'b1, r, k, w};
    @(posedge mclk);
    cmd_valid <= 1'b0;
    i_host.rd(8'h00, d);
    chk("illegal", 64'(d[8]), 64'(e));
  endtask : cmd

  // Main sequence.
  initial begin
    void'($urandom(32'h388f));
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    i_host.rd(8'h00, d);
    chk("ctx", 64'(d), 64'h0);
    i_host.rd(8'h08, d);
    chk("unmapped", 64'(d), 64'h0);
    cls(1'b0, 64'h80000000, 3'h0);
    cls(1'b0, 64'h00000001, 3'h1);
    cls(1'b0, 64'h00800000, 3'h2);
    cls(1'b0, 64'h7f7fffff, 3'h2);
    cls(1'b0, 64'hff800000, 3'h3);
    cls(1'b0, 64'h7f800001, 3'h4);
    cls(1'b1, 64'h7fefffffffffffff, 3'h2);
    cls(1'b1, 64'h0010000000000000, 3'h2);
    cls(1'b0, 64'h00000000, 3'h0);
    // Random rounding in all modes with ties, exact values and sticky tails.
    for (int i = 0; i < 60; i++) begin
      md = $urandom % 4;
      s = 1'($urandom);
      fr = {1'b0, 22'($urandom)};
      lo = (i % 3 == 0) ? 32'h80000000 : (i % 3 == 1) ? $urandom : 32'h0;
      g = lo[31];
      st = |lo[30:0];
      up = (md == 0) ? g & (st | fr[0]) : (md == 1) ? 1'b0 : (md == 2) ? ~s & (g | st) : s & (g | st);
      i_host.wr(8'h00, 32'(md));
      op(fp_round_pkg::op_move, 64'h0, 64'h0, s, 13'h007f, {1'b1, fr, lo});
      chk("rounded", result, {32'h0, s, 8'h7f, fr + 23'(up)});
      chk("inexact", 64'(result_flags), {62'h0, g | st, 1'b0});
    end
    // Overflow in every mode and sign.
    for (int i = 0; i < 8; i++) begin
      md = i / 2;
      s = 1'(i);
      i_host.wr(8'h00, 32'(md));
      op(fp_round_pkg::op_move, 64'h0, 64'h0, s, 13'h00ff, unit_mant);
      want = {32'h0, s, (md == 0 || md == 2 + s) ? 31'h7f800000 : 31'h7f7fffff};
      chk("overflow", result, want);
      chk("ovf_flags", 64'(result_flags), 64'h6);
    end
    // Double precision: toward-zero overflow and the default NaN of an invalid product.
    i_host.wr(8'h00, 32'h1);
    @(posedge mclk) op_double <= 1'b1;
    op(fp_round_pkg::op_move, 64'h0, 64'h0, 1'b0, 13'h0800, unit_mant);
    chk("dbl_overflow", result, 64'h7fefffffffffffff);
    run(fp_round_pkg::op_mul, 64'h7ff0000000000000, 64'h0, 64'h7fffffffffffffff, 6'h20);
    @(posedge mclk) op_double <= 1'b0;
    i_host.wr(8'h00, 32'h0);
    op(fp_round_pkg::op_move, 64'h0, 64'h0, 1'b1, 13'h0000, unit_mant);
    chk("underflow", result, 64'h80000000);
    chk("unf_flags", 64'(result_flags), 64'h8);
    op(fp_round_pkg::op_move, 64'h0, 64'h0, 1'b0, 13'h007f, 56'h1);
    chk("unnormal", result, 64'h0);
    chk("unn_flags", 64'(result_flags), 64'h8);
    op(fp_round_pkg::op_move, 64'h0, 64'h0, 1'b0, 13'h007f, 56'h0);
    chk("exact_zero", result, 64'h0);
    chk("zero_flags", 64'(result_flags), 64'h0);
    op(fp_round_pkg::op_fix, 64'hd3800000, 64'h0, 1'b1, 13'h00a7, unit_mant);
    chk("fix_range", result, 64'h80000000);
    chk("fix_ovf", 64'(result_flags[2]), 64'h1);
    op(fp_round_pkg::op_fix, 64'h3fc00000, 64'h0, 1'b0, 13'h007f, 56'hc0000000000000);
    chk("fix_lossy", result, 64'h2);
    chk("fix_inexact", 64'(result_flags[1]), 64'h1);
    run(fp_round_pkg::op_div, 64'h3f800000, 64'h80000000, 64'hff800000, 6'h10);
    run(fp_round_pkg::op_div, 64'h0, 64'h0, 64'h7fffffff, 6'h20);
    run(fp_round_pkg::op_div, 64'h7f800000, 64'hff800000, 64'h7fffffff, 6'h20);
    run(fp_round_pkg::op_sub, 64'h7f800000, 64'h7f800000, 64'h7fffffff, 6'h20);
    run(fp_round_pkg::op_add, 64'hff800000, 64'h7f800000, 64'h7fffffff, 6'h20);
    run(fp_round_pkg::op_add, 64'h7fc00000, 64'h3f800000, 64'h7fffffff, 6'h20);
    run(fp_round_pkg::op_mul, 64'h00000001, 64'h7f800000, 64'h7fffffff, 6'h20);
    cmd(1'b1, 1'b1, 1'b0, 1'b1);
    cmd(1'b0, 1'b0, 1'b0, 1'b1);
    cmd(1'b1, 1'b1, 1'b1, 1'b0);
    cmd(1'b0, 1'b1, 1'b0, 1'b0);
    // Enabled invalid flag: interrupt, persistence across ops, clear by write.
    i_host.wr(8'h00, 32'h80);
    run(fp_round_pkg::op_mul, 64'h7f800000, 64'h0, 64'h7fffffff, 6'h20);
    chk("irq_on", 64'(irq), 64'h1);
    op(fp_round_pkg::op_move, 64'h0, 64'h0, 1'b0, 13'h007f, unit_mant);
    i_host.rd(8'h00, d);
    chk("sticky", {d[13:8], 57'h0, irq}, {6'h20, 58'h1});
    i_host.wr(8'h00, 32'h80);
    i_host.rd(8'h00, d);
    chk("cleared", {d[13:8], 57'h0, irq}, 64'h0);
    i_host.wr(8'h00, 32'h0);
    run(fp_round_pkg::op_mul, 64'h7f800000, 64'h0, 64'h7fffffff, 6'h20);
    chk("irq_masked", 64'(irq), 64'h0);
    wrap_up();
  end
endmodule : fp_round_and_exception_unit_bench
